// file: rtl/tccio_pkg.sv
// Constants, types and register map of the five-channel compare/capture I/O and status block.
// Assumes an APB3 master with 32-bit data and byte addresses on an 8-bit paddr.
// Behaviour
// RQ1 - Five identical channels; channel 2 differs slightly
// RQ2 - I/O control resets to 0x88, also standby
// RQ3 - I/O control bits 7, 3 read one
// RQ4 - B compare codes: none, 0, 1, toggle
// RQ5 - B capture: rising, falling, both; 11 undefined
// RQ6 - A compare codes same as B side
// RQ7 - A capture: rising, falling or both edges
// RQ8 - Channel 2 toggle code drives one instead
// RQ9 - Compare pins hold 0 until first match
// RQ10 - Status resets 0xF8; bits 7..3 read one
// RQ11 - Wrap flag on up or down wrap
// RQ12 - Down wrap only channel 2 phase counting
// RQ13 - B flag on B compare match
// RQ14 - B flag on capture into B
// RQ15 - A flag on A compare match
// RQ16 - A flag on capture into A
// RQ17 - Flag clears by zero write after read-one
// RQ18 - Flags request interrupt only when enabled
// RQ19 - Enable bits: wrap 2, B 1, A 0
// RQ20 - Write one keeps flag; set beats clear
package tccio_pkg;
  localparam int NCH = 5;
  localparam int CH_SPECIAL = 2;
  localparam logic [4:0] CH_STRIDE_SHIFT = 5'h05;
  // Per-channel word offsets within a channel's window
  localparam logic [2:0] REG_IOCTL = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_IRQEN = 3'h2;
  localparam logic [2:0] REG_GRA = 3'h3;
  localparam logic [2:0] REG_GRB = 3'h4;
  localparam logic [7:0] ADDR_MODE = 8'ha0;
  localparam logic [7:0] IOCTL_RESET = 8'h88;
  localparam logic [7:0] IOCTL_FIXED = 8'h88;
  localparam logic [7:0] STATUS_FIXED = 8'hf8;
  localparam logic [7:0] IRQEN_FIXED = 8'hf8;
  localparam logic [2:0] FLAGS_RESET = 3'h0;
  localparam logic [15:0] GR_RESET = 16'hffff;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_MIN = 16'h0000;
  localparam int B_FIELD_LSB = 4;
  localparam int A_FIELD_LSB = 0;
  localparam int FLAG_WRAP = 2;
  localparam int FLAG_B = 1;
  localparam int FLAG_A = 0;
  localparam int MODE_PHASE_BIT = 0;

  typedef enum logic [1:0] {
    TCCIO_ACT_NONE = 2'b00,
    TCCIO_ACT_ZERO = 2'b01,
    TCCIO_ACT_ONE = 2'b10,
    TCCIO_ACT_TOGGLE = 2'b11
  } tccio_act_t;

  typedef enum logic [1:0] {
    TCCIO_EDGE_RISE = 2'b00,
    TCCIO_EDGE_FALL = 2'b01,
    TCCIO_EDGE_BOTH = 2'b10,
    TCCIO_EDGE_NONE = 2'b11
  } tccio_edge_t;

  // Counter of one channel as seen by this block
  typedef struct packed {
    logic [15:0] value;
    logic down;
  } tccio_cnt_t;

  // Pin drive of one channel; oe_n low while the pin is driven
  typedef struct packed {
    logic a_out;
    logic a_oe_n;
    logic b_out;
    logic b_oe_n;
  } tccio_pin_t;
endpackage

// file: rtl/tccio_top.sv
// Compare/capture pin control, general registers A/B and event flags for five timer channels.
// Assumes counters are supplied per channel, pins are synchronous to pclk, standby is a level.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module tccio_top import tccio_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic standby,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tccio_cnt_t cnt_i [NCH],
  input wire logic [NCH-1:0] channel_pin_a_in,
  input wire logic [NCH-1:0] channel_pin_b_in,
  output tccio_pin_t pin_o [NCH],
  output logic [2:0] irq_req [NCH]
);

  logic [7:0] ioctl_r [NCH];
  logic [2:0] flag_r [NCH];
  logic [2:0] arm_r [NCH];
  logic [2:0] irqen_r [NCH];
  logic [15:0] gra_r [NCH];
  logic [15:0] grb_r [NCH];
  logic [15:0] cnt_prev_r [NCH];
  logic [NCH-1:0] pa_prev_r;
  logic [NCH-1:0] pb_prev_r;
  logic [NCH-1:0] pa_out_r;
  logic [NCH-1:0] pb_out_r;
  logic phase_mode_r;
  logic [31:0] prdata_r;
  logic [2:0] irq_r [NCH];

  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic dec_ok;
  logic dec_mode;
  logic [2:0] dec_ch;
  logic [2:0] dec_reg;
  logic [31:0] rd_mux;

  logic [NCH-1:0] match_a;
  logic [NCH-1:0] match_b;
  logic [NCH-1:0] cap_a;
  logic [NCH-1:0] cap_b;
  logic [NCH-1:0] wrap;
  logic [2:0] set_ev [NCH];
  logic [NCH-1:0] st_hit;
  logic [2:0] clr_mask [NCH];

  // Edge qualifier for a capture field; code 11 never captures
  function automatic logic edge_hit(input logic [1:0] code, input logic prev, input logic cur);
    logic r;
    r = 1'b0;
    case (code)
      TCCIO_EDGE_RISE: r = !prev && cur;
      TCCIO_EDGE_FALL: r = prev && !cur;
      TCCIO_EDGE_BOTH: r = prev != cur;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Next pin level at a compare match
  function automatic logic pin_next(input logic [1:0] code, input logic cur, input logic special);
    logic r;
    r = cur;
    case (code)
      TCCIO_ACT_NONE: r = cur;
      TCCIO_ACT_ZERO: r = 1'b0;
      TCCIO_ACT_ONE: r = 1'b1;
      TCCIO_ACT_TOGGLE: r = special ? 1'b1 : !cur;
      default: r = cur;
    endcase
    return r;
  endfunction

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite && dec_ok;
  assign rd = access && !pwrite && dec_ok;
  // No wait states: every register answers in the access cycle
  assign pready = 1'b1;
  assign pslverr = access && !dec_ok;
  assign prdata = prdata_r;

  // Address decode: 32-byte window per channel, mode register above them
  always_comb begin
    dec_ch = paddr[7:5];
    dec_reg = paddr[4:2];
    dec_mode = paddr == ADDR_MODE;
    dec_ok = dec_mode || (paddr[1:0] == 2'b00 && 32'(dec_ch) < NCH && dec_reg <= REG_GRB);
  end

  always_comb begin
    rd_mux = 32'h0;
    if (dec_mode) begin
      rd_mux = {31'h0, phase_mode_r};
    end else if (dec_ok) begin
      case (dec_reg)
        REG_IOCTL: rd_mux = {24'h0, ioctl_r[dec_ch] | IOCTL_FIXED}; // [RQ3]
        REG_STATUS: rd_mux = {24'h0, STATUS_FIXED | {5'h0, flag_r[dec_ch]}}; // [RQ10]
        REG_IRQEN: rd_mux = {24'h0, IRQEN_FIXED | {5'h0, irqen_r[dec_ch]}};
        REG_GRA: rd_mux = {16'h0, gra_r[dec_ch]};
        REG_GRB: rd_mux = {16'h0, grb_r[dec_ch]};
        default: rd_mux = 32'h0;
      endcase
    end
  end

  // Read data is registered in the setup cycle so it comes from a flop in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (setup && !pwrite) begin
      prdata_r <= rd_mux;
    end
  end

  // Event detection per channel
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      logic special;
      logic b_cap_mode;
      logic a_cap_mode;
      special = c == CH_SPECIAL;
      b_cap_mode = ioctl_r[c][B_FIELD_LSB+2];
      a_cap_mode = ioctl_r[c][A_FIELD_LSB+2];
      match_a[c] = !a_cap_mode && cnt_i[c].value == gra_r[c] && cnt_i[c].value != cnt_prev_r[c]; // [RQ15]
      match_b[c] = !b_cap_mode && cnt_i[c].value == grb_r[c] && cnt_i[c].value != cnt_prev_r[c]; // [RQ13]
      cap_a[c] = a_cap_mode &&
                 edge_hit(ioctl_r[c][A_FIELD_LSB+:2], pa_prev_r[c], channel_pin_a_in[c]); // [RQ7]
      cap_b[c] = b_cap_mode &&
                 edge_hit(ioctl_r[c][B_FIELD_LSB+:2], pb_prev_r[c], channel_pin_b_in[c]); // [RQ5]
      // Up wrap in any channel; down wrap only in the special channel with phase counting selected [RQ11] [RQ12]
      wrap[c] = (!(special && phase_mode_r && cnt_i[c].down) &&
                 cnt_prev_r[c] == CNT_MAX && cnt_i[c].value == CNT_MIN) ||
                (special && phase_mode_r && cnt_i[c].down &&
                 cnt_prev_r[c] == CNT_MIN && cnt_i[c].value == CNT_MAX);
      set_ev[c] = {wrap[c], match_b[c] || cap_b[c], match_a[c] || cap_a[c]}; // [RQ14] [RQ16]
    end
  end

  // History of counter and pin inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++) begin
        cnt_prev_r[c] <= CNT_MIN;
      end
      pa_prev_r <= '0;
      pb_prev_r <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        cnt_prev_r[c] <= cnt_i[c].value;
      end
      pa_prev_r <= channel_pin_a_in;
      pb_prev_r <= channel_pin_b_in;
    end
  end

  // Mode register: phase counting select for the special channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_mode_r <= 1'b0;
    end else if (standby) begin
      phase_mode_r <= 1'b0;
    end else if (wr && dec_mode) begin
      phase_mode_r <= pwdata[MODE_PHASE_BIT];
    end
  end

  // I/O control and interrupt enable; fixed control bits are stored as ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++) begin
        ioctl_r[c] <= IOCTL_RESET; // [RQ2]
        irqen_r[c] <= FLAGS_RESET;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (standby) begin
          ioctl_r[c] <= IOCTL_RESET; // [RQ2]
          irqen_r[c] <= FLAGS_RESET;
        end else if (wr && !dec_mode && 32'(dec_ch) == c) begin
          if (dec_reg == REG_IOCTL) begin
            ioctl_r[c] <= pwdata[7:0] | IOCTL_FIXED; // [RQ3]
          end
          if (dec_reg == REG_IRQEN) begin
            irqen_r[c] <= pwdata[2:0]; // [RQ19]
          end
        end
      end
    end
  end

  // General registers; a capture in the same cycle overrides a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++) begin
        gra_r[c] <= GR_RESET;
        grb_r[c] <= GR_RESET;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (standby) begin
          gra_r[c] <= GR_RESET;
          grb_r[c] <= GR_RESET;
        end else begin
          if (cap_a[c]) begin
            gra_r[c] <= cnt_i[c].value; // [RQ7]
          end else if (wr && !dec_mode && 32'(dec_ch) == c && dec_reg == REG_GRA) begin
            gra_r[c] <= pwdata[15:0];
          end
          if (cap_b[c]) begin
            grb_r[c] <= cnt_i[c].value; // [RQ5]
          end else if (wr && !dec_mode && 32'(dec_ch) == c && dec_reg == REG_GRB) begin
            grb_r[c] <= pwdata[15:0];
          end
        end
      end
    end
  end

  // Status write decode: only armed flags written with zero are cleared [RQ17] [RQ20]
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      st_hit[c] = !dec_mode && 32'(dec_ch) == c && dec_reg == REG_STATUS;
      clr_mask[c] = (wr && st_hit[c]) ? (arm_r[c] & ~pwdata[2:0]) : 3'h0;
    end
  end

  // Flags: a read that sees a flag at one arms it; the next status write clears armed flags written with zero and disarms all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++) begin
        flag_r[c] <= FLAGS_RESET; // [RQ10]
        arm_r[c] <= FLAGS_RESET;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (standby) begin
          flag_r[c] <= FLAGS_RESET; // [RQ10]
          arm_r[c] <= FLAGS_RESET;
        end else begin
          flag_r[c] <= (flag_r[c] & ~clr_mask[c]) | set_ev[c]; // [RQ20]
          // Arm from the data the read returned, so a flag set after setup is never armed unseen
          if (rd && st_hit[c]) begin
            arm_r[c] <= arm_r[c] | prdata_r[2:0]; // [RQ17]
          end else if (wr && st_hit[c]) begin
            arm_r[c] <= FLAGS_RESET;
          end
        end
      end
    end
  end

  // Interrupt requests, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++) begin
        irq_r[c] <= FLAGS_RESET;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        irq_r[c] <= flag_r[c] & irqen_r[c]; // [RQ18]
      end
    end
  end

  // Compare pin levels; 0 from reset until a match acts [RQ9]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_out_r <= '0;
      pb_out_r <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (standby) begin
          pa_out_r[c] <= 1'b0;
          pb_out_r[c] <= 1'b0;
        end else begin
          if (match_a[c]) begin
            pa_out_r[c] <= pin_next(ioctl_r[c][A_FIELD_LSB+:2], pa_out_r[c], c == CH_SPECIAL); // [RQ6] [RQ8]
          end
          if (match_b[c]) begin
            pb_out_r[c] <= pin_next(ioctl_r[c][B_FIELD_LSB+:2], pb_out_r[c], c == CH_SPECIAL); // [RQ4] [RQ8]
          end
        end
      end
    end
  end

  // A pin is driven only when set for compare with an action other than none
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      pin_o[c].a_out = pa_out_r[c];
      pin_o[c].b_out = pb_out_r[c];
      pin_o[c].a_oe_n = ioctl_r[c][A_FIELD_LSB+2] || ioctl_r[c][A_FIELD_LSB+:2] == TCCIO_ACT_NONE;
      pin_o[c].b_oe_n = ioctl_r[c][B_FIELD_LSB+2] || ioctl_r[c][B_FIELD_LSB+:2] == TCCIO_ACT_NONE;
      irq_req[c] = irq_r[c];
    end
  end

  // Checks, one set per channel [RQ1]
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  for (genvar g = 0; g < NCH; g++) begin : g_chk

    standby_init_a: assert property (standby |=> ioctl_r[g] == IOCTL_RESET && flag_r[g] == FLAGS_RESET) // [RQ2]
      else $error("standby did not reinitialise channel");
    fixed_bits_a: assert property (ioctl_r[g][7] && ioctl_r[g][3]) // [RQ3]
      else $error("fixed control bits lost");
    b_drive_one_a: assert property (!standby && match_b[g] && ioctl_r[g][6:4] == 3'b010 |=> pb_out_r[g]) // [RQ4]
      else $error("B pin not driven high on match");
    a_drive_zero_a: assert property (!standby && match_a[g] && ioctl_r[g][2:0] == 3'b001 |=> !pa_out_r[g]) // [RQ6]
      else $error("A pin not driven low on match");
    if (g == CH_SPECIAL) begin : g_sp
      special_toggle_a: assert property (!standby && match_a[g] && ioctl_r[g][2:0] == 3'b011 |=> pa_out_r[g]) // [RQ8]
        else $error("special channel toggle did not give one");
      down_wrap_a: assert property (!standby && phase_mode_r && cnt_i[g].down && cnt_prev_r[g] == CNT_MIN // [RQ12]
                                    && cnt_i[g].value == CNT_MAX |=> flag_r[g][FLAG_WRAP])
        else $error("underflow flag not set");
    end else begin : g_nsp
      toggle_flip_a: assert property (!standby && match_a[g] && ioctl_r[g][2:0] == 3'b011 // [RQ6]
                                      |=> pa_out_r[g] != $past(pa_out_r[g]))
        else $error("A pin did not toggle");
      no_down_wrap_a: assert property (!standby && cnt_prev_r[g] == CNT_MIN && cnt_i[g].value == CNT_MAX // [RQ12]
                                       |=> flag_r[g][FLAG_WRAP] == $past(flag_r[g][FLAG_WRAP])
                                           || $past(wr))
        else $error("underflow flagged outside special channel");
    end
    capture_a_a: assert property (!standby && cap_a[g] // [RQ16]
                                  |=> gra_r[g] == $past(cnt_i[g].value) && flag_r[g][FLAG_A])
      else $error("A capture lost value or flag");
    capture_b_a: assert property (!standby && cap_b[g] |=> grb_r[g] == $past(cnt_i[g].value)) // [RQ5]
      else $error("B capture lost value");
    a_flag_set_a: assert property (!standby && (match_a[g] || cap_a[g]) |=> flag_r[g][FLAG_A]) // [RQ15]
      else $error("A flag not set");
    b_flag_set_a: assert property (!standby && (match_b[g] || cap_b[g]) |=> flag_r[g][FLAG_B]) // [RQ13]
      else $error("B flag not set");
    wrap_set_a: assert property (!standby && cnt_prev_r[g] == CNT_MAX && cnt_i[g].value == CNT_MIN // [RQ11]
                                 && !cnt_i[g].down |=> flag_r[g][FLAG_WRAP])
      else $error("wrap flag not set");
    unarmed_clear_a: assert property (!standby && arm_r[g] == FLAGS_RESET // [RQ17]
                                      |=> (flag_r[g] & $past(flag_r[g])) == $past(flag_r[g]))
      else $error("flag cleared without prior read");
    armed_clear_a: assert property (!standby && wr && st_hit[g] // [RQ17]
                                    |=> (flag_r[g] & $past(clr_mask[g]) & ~$past(set_ev[g])) == FLAGS_RESET)
      else $error("armed flag not cleared");
    set_wins_a: assert property (!standby && set_ev[g] != FLAGS_RESET // [RQ20]
                                 |=> (flag_r[g] & $past(set_ev[g])) == $past(set_ev[g]))
      else $error("flag set lost to clear");
    irq_gate_a: assert property (irq_req[g] != FLAGS_RESET // [RQ18]
                                 |-> irq_req[g] == ($past(flag_r[g]) & $past(irqen_r[g])))
      else $error("interrupt without enabled flag");
    b_oe_drive_a: assert property (!ioctl_r[g][6] && ioctl_r[g][5:4] != 2'b00 |-> !pin_o[g].b_oe_n) // [RQ4]
      else $error("B pin not driven in compare mode");
    pin_idle_a: assert property ($rose(presetn) |-> !pa_out_r[g] && !pb_out_r[g]) // [RQ9]
      else $error("pin not low after reset");

    cap_b_c: cover property (cap_b[g] ##1 flag_r[g][FLAG_B]);
    clear_c: cover property (rd && arm_r[g] == FLAGS_RESET ##1 arm_r[g] != FLAGS_RESET
                             ##[1:8] flag_r[g] == FLAGS_RESET);
    toggle_c: cover property (match_b[g] && ioctl_r[g][5:4] == 2'b11);
    down_wrap_c: cover property (phase_mode_r && wrap[g] && cnt_i[g].down);
    set_clear_c: cover property (wr && st_hit[g] && clr_mask[g] != FLAGS_RESET);
  end

endmodule

// file: test/tccio_pin_env.sv
// Far-side pin model: resolves each two-way channel pin from the block's drive and an external source.
// Assumes the external source drives all the time; the block wins while its oe_n is low.
`timescale 1ns/1ps
module tccio_pin_env import tccio_pkg::*; (
  input wire tccio_pin_t pin_o [NCH],
  input wire logic [NCH-1:0] ext_a,
  input wire logic [NCH-1:0] ext_b,
  output logic [NCH-1:0] pin_a,
  output logic [NCH-1:0] pin_b
);
  // A driven pin reads back its own level, as on a real pad
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      pin_a[i] = pin_o[i].a_oe_n ? ext_a[i] : pin_o[i].a_out;
      pin_b[i] = pin_o[i].b_oe_n ? ext_b[i] : pin_o[i].b_out;
    end
  end
endmodule

// file: test/tb_top.sv
// Self-checking bench for the compare/capture pin control and event flags, APB master included.
// Assumes the pin model of tccio_pin_env and the register map of tccio_pkg.
`timescale 1ns/1ps
module tb_top;
  import tccio_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, standby = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_d, e;
  logic pready, pslverr, rd_e;
  tccio_cnt_t cnt [NCH];
  tccio_pin_t pin_o [NCH];
  logic [2:0] irq [NCH];
  logic [NCH-1:0] ext_a = 5'h00, ext_b = 5'h00, pin_a, pin_b;
  logic [15:0] v;
  int error_cnt = 0, checked = 0, seed = 13470;
  int pa [NCH];
  int cs [5] = '{2, 1, 3, 3, 0};

  always #25 pclk = ~pclk;

  tccio_top i_dut (.pclk(pclk), .presetn(presetn), .standby(standby), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cnt_i(cnt), .channel_pin_a_in(pin_a), .channel_pin_b_in(pin_b), .pin_o(pin_o), .irq_req(irq));
  tccio_pin_env i_pin (.pin_o(pin_o), .ext_a(ext_a), .ext_b(ext_b), .pin_a(pin_a), .pin_b(pin_b));

  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Zero-wait slave today, but the wait is bounded so a stuck pready ends the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      print_verdict;
    end else begin
      rd_d = prdata;
      rd_e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd_d, exp);
  endtask

  function automatic logic [7:0] ad(input int c, input logic [2:0] r);
    return 8'(c * 32 + 4 * r);
  endfunction

  // Read arms the flags seen at one, the zero write then clears them
  task automatic clr(input int c);
    apb(1'b0, ad(c, REG_STATUS), 32'h0);
    wr(ad(c, REG_STATUS), 32'h0);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  initial begin
    for (int i = 0; i < NCH; i++) begin
      cnt[i] <= '0;
      pa[i] = 0;
    end
    tick(6);
    presetn <= 1'b1;
    for (int c = 0; c < NCH; c++) begin
      rchk("ioctl reset", ad(c, REG_IOCTL), 32'h88);
      rchk("status reset", ad(c, REG_STATUS), 32'hf8);
      rchk("irqen reset", ad(c, REG_IRQEN), 32'hf8);
      chk("pin a reset", pin_o[c].a_out, 32'h0);
      chk("pin b reset", pin_o[c].b_out, 32'h0);
    end
    wr(ad(3, REG_IOCTL), 32'h77);
    rchk("ioctl fixed one", ad(3, REG_IOCTL), 32'hff);
    wr(ad(3, REG_IOCTL), 32'h00);
    rchk("ioctl fixed zero", ad(3, REG_IOCTL), 32'h88);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped err", rd_e, 32'h1);
    chk("unmapped data", rd_d, 32'h0);
    // Compare codes in every channel; same code on both sides each step
    for (int c = 0; c < NCH; c++) begin
      v = (16'($random(seed)) & 16'h7ffe) | 16'h0002;
      wr(ad(c, REG_GRA), {16'h0, v});
      wr(ad(c, REG_GRB), {16'h0, v});
      for (int k = 0; k < 5; k++) begin
        wr(ad(c, REG_IOCTL), 32'h88 | (cs[k] << 4) | cs[k]);
        cnt[c].value <= v - 16'h1;
        tick(1);
        cnt[c].value <= v;
        tick(3);
        pa[c] = cs[k] == 1 ? 0 : (cs[k] == 2 || (cs[k] == 3 && c == CH_SPECIAL)) ? 1 : cs[k] == 3 ? 1 - pa[c] : pa[c];
        chk("pin a", pin_o[c].a_out, pa[c] & 1);
        chk("pin b", pin_o[c].b_out, pa[c] & 1);
        chk("oe a", pin_o[c].a_oe_n, cs[k] == 0);
        chk("oe b", pin_o[c].b_oe_n, cs[k] == 0);
      end
      rchk("match flags", ad(c, REG_STATUS), 32'hfb);
    end
    chk("irq masked", irq[0], 32'h0);
    wr(ad(0, REG_IRQEN), 32'h02);
    rchk("irqen b", ad(0, REG_IRQEN), 32'hfa);
    chk("irq b only", irq[0], 32'h2);
    wr(ad(0, REG_IRQEN), 32'h07);
    tick(2);
    chk("irq all", irq[0], 32'h3);
    wr(ad(0, REG_STATUS), 32'hff);
    wr(ad(0, REG_STATUS), 32'h00);
    rchk("zero write unarmed", ad(0, REG_STATUS), 32'hfb);
    wr(ad(0, REG_STATUS), 32'hff);
    rchk("one write keeps", ad(0, REG_STATUS), 32'hfb);
    wr(ad(0, REG_STATUS), 32'h00);
    rchk("armed clear", ad(0, REG_STATUS), 32'hf8);
    tick(2);
    chk("irq after clear", irq[0], 32'h0);
    cnt[0] <= '{16'h0000, 1'b1};
    tick(1);
    cnt[0] <= '{16'hffff, 1'b1};
    tick(3);
    rchk("no down wrap ch0", ad(0, REG_STATUS), 32'hf8);
    cnt[0] <= '{16'h0000, 1'b0};
    tick(3);
    rchk("up wrap", ad(0, REG_STATUS), 32'hfc);
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_MODE, m);
      rchk("mode", ADDR_MODE, m);
      clr(2);
      cnt[2] <= '{16'h0000, 1'b1};
      tick(1);
      cnt[2] <= '{16'hffff, 1'b1};
      tick(3);
      rchk("down wrap ch2", ad(2, REG_STATUS), 32'hf8 | (m << 2));
    end
    // Rise then fall on channel 1 pins; the stored value tells which edge captured
    for (int code = 0; code < 4; code++) begin
      clr(1);
      wr(ad(1, REG_IOCTL), 32'hcc | (code << 4) | code);
      wr(ad(1, REG_GRA), 32'h1234);
      wr(ad(1, REG_GRB), 32'h1234);
      cnt[1] <= '{{8'h01, 8'(code)}, 1'b0};
      ext_a[1] <= 1'b1;
      ext_b[1] <= 1'b1;
      tick(3);
      cnt[1] <= '{{8'h02, 8'(code)}, 1'b0};
      ext_a[1] <= 1'b0;
      ext_b[1] <= 1'b0;
      tick(3);
      e = code == 0 ? 32'h0100 + code : code == 3 ? 32'h1234 : 32'h0200 + code;
      rchk("capture a", ad(1, REG_GRA), e);
      rchk("capture b", ad(1, REG_GRB), e);
      rchk("capture flags", ad(1, REG_STATUS), code == 3 ? 32'hf8 : 32'hfb);
    end
    wr(ad(4, REG_IOCTL), 32'hff);
    standby <= 1'b1;
    tick(1);
    standby <= 1'b0;
    rchk("standby ioctl", ad(4, REG_IOCTL), 32'h88);
    rchk("standby status", ad(4, REG_STATUS), 32'hf8);
    print_verdict;
  end
endmodule
